// *** lpddr_bank_ap.sv ***
// per-bank auto precharge timer with row-active lock-out
`timescale 1ns/100ps
`default_nettype none
`include "lpddr_pwr_regs.svh"
module lpddr_bank_ap import lpddr_pwr_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic act,
  input wire logic col_ap,
  input wire logic is_write,
  input wire logic pre,
  output logic open_o,
  output logic ap_busy_o
);
  typedef struct packed {
    logic open;
    logic [4:0] ras;
    bank_ap_s ap;
  } st_s;
  st_s r, nxt;
  always_comb begin
    nxt = r;
    if (r.ras != 5'h00) nxt.ras = r.ras - 5'h01;
    if (act) begin
      nxt.open = 1'b1;
      nxt.ras = 5'(`T_RAS_CYC);
    end
    if (pre) nxt.open = 1'b0;
    if (col_ap && r.open) begin
      // write keeps recovery time before precharge starts
      nxt.ap.busy = 1'b1;
      nxt.ap.cnt = is_write ? 5'(`BURST_CYC + `T_WR_CYC) : 5'(`BURST_CYC);
    end else if (r.ap.busy) begin
      if (r.ap.cnt != 5'h00) nxt.ap.cnt = r.ap.cnt - 5'h01;
      else if (r.ras == 5'h00) begin
        nxt.ap.busy = 1'b0;
        nxt.open = 1'b0;
      end
    end
    if (!nrst) nxt = '0;
  end
  always_ff @(posedge clk) begin
    r <= nxt;
  end
  assign open_o = r.open;
  assign ap_busy_o = r.ap.busy;
endmodule // lpddr_bank_ap
`default_nettype wire

// *** lpddr_ctrl_model.sv ***
// controller model driving cke and the command pins
`timescale 1ns/100ps
`default_nettype none
module lpddr_ctrl_model import lpddr_pwr_pkg::*; (
  input wire logic clk,
  output var logic cke_pin,
  output var cmd_bus_s cmd_pin
);
  initial begin
    cke_pin = 1'b1;
    cmd_pin = 7'h38;
  end
  // one command per edge; cke and the bus hold until the next call
  task automatic put(input logic [3:0] c, input logic k, input logic a, input logic [1:0] b,
    input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      cke_pin <= k;
      cmd_pin <= {c, a, b};
    end
  endtask
endmodule // lpddr_ctrl_model
`default_nettype wire

// *** lpddr_pwr_pkg.sv ***
// types for the refresh and power-state block
package lpddr_pwr_pkg;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_ACTIVE = 8'h02, ST_REFRESH = 8'h04, ST_SELF_REF = 8'h08,
    ST_PD_PRE = 8'h10, ST_PD_ACT = 8'h20, ST_DEEP = 8'h40, ST_CLK_STOP = 8'h80
  } pwr_state_e;
  typedef enum logic [3:0] {
    CMD_NOP, CMD_DESEL, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_REF, CMD_MRS, CMD_BST
  } cmd_e;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic a10;
    logic [1:0] ba;
  } cmd_bus_s;
  typedef struct packed {
    logic busy;
    logic [4:0] cnt;
  } bank_ap_s;
  typedef struct packed {
    logic [2:0] pasr;
    logic [1:0] temp;
  } sr_cfg_s;
endpackage

// *** lpddr_pwr_regs.svh ***
// timing counts and sizes for the refresh and power-state block
`ifndef LPDDR_PWR_REGS_SVH
`define LPDDR_PWR_REGS_SVH
`define CLK_PERIOD_NS 10
`define T_RFC_NS 72
`define T_RFC_CYC ((`T_RFC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_XSR_NS 112
`define T_XSR_CYC ((`T_XSR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RAS_NS 42
`define T_RAS_CYC ((`T_RAS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WR_NS 15
`define T_WR_CYC ((`T_WR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RP_NS 15
`define T_RP_CYC ((`T_RP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SR_BASE_CYC 780
`define BURST_CYC 2
`define ROW_W 14
`define NUM_BANKS 4
`endif

// *** lpddr_refresh_power_state.sv ***
// refresh and power-state control of a low-power ddr sdram device
// Behaviour
// - other banks usable during auto precharge
// - refresh rows come from internal counter
// - refresh with cke low enters self refresh
// - self refresh internal, partial array, temperature rate
// - power-down disables buffers except cke
// - deepest sleep on coded command, loses data
// - auto precharge at earliest legal point
`timescale 1ns/100ps
`default_nettype none
`include "lpddr_pwr_regs.svh"
module lpddr_refresh_power_state import lpddr_pwr_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cke_pin,
  input wire cmd_bus_s cmd_pin,
  input wire logic clk_running,
  input wire sr_cfg_s sr_cfg,
  output logic [7:0] pwr_state,
  output logic buffers_on,
  output logic refresh_pulse,
  output logic [`ROW_W-1:0] refresh_row,
  output logic [`NUM_BANKS-1:0] refresh_bank_en,
  output logic [`NUM_BANKS-1:0] bank_open,
  output logic array_lost,
  output logic need_init
);
  typedef struct packed {
    logic cke_s1;
    logic cke_s2;
    logic run_s1;
    logic run_s2;
    cmd_bus_s cmd_s1;
    cmd_bus_s cmd_s2;
    pwr_state_e st;
    logic [12:0] cnt;
    logic [`ROW_W-1:0] row;
    logic [`NUM_BANKS-1:0] open_v;
    logic [`NUM_BANKS-1:0] ref_en;
    logic ref_p;
    logic bufs;
    logic lost;
    logic init;
  } st_s;
  st_s r, nxt;
  logic [`NUM_BANKS-1:0] b_open, b_ap;
  logic [`NUM_BANKS-1:0] act_v, col_v, pre_v;
  cmd_e cmd;

  function automatic cmd_e decode(input cmd_bus_s c);
    if (c.cs_n) decode = CMD_DESEL;
    else unique case ({c.ras_n, c.cas_n, c.we_n})
      3'b111: decode = CMD_NOP;
      3'b011: decode = CMD_ACT;
      3'b101: decode = CMD_READ;
      3'b100: decode = CMD_WRITE;
      3'b010: decode = CMD_PRE;
      3'b001: decode = CMD_REF;
      3'b000: decode = CMD_MRS;
      default: decode = CMD_BST;
    endcase
  endfunction

  // self refresh interval stretched when cool, each level doubles it
  // just wide enough so the coolest step does not wrap
  function automatic logic [12:0] sr_interval(input logic [1:0] t);
    sr_interval = 13'(`SR_BASE_CYC) << t;
  endfunction

  function automatic logic [`NUM_BANKS-1:0] pasr_mask(input logic [2:0] p);
    unique case (p)
      3'h1: pasr_mask = 4'h3;
      3'h2: pasr_mask = 4'h1;
      default: pasr_mask = 4'hf;
    endcase
  endfunction

  assign cmd = decode(r.cmd_s2);

  generate
    for (genvar b = 0; b < `NUM_BANKS; b++) begin : g_bank
      always_comb begin
        act_v[b] = r.cke_s2 && cmd == CMD_ACT && r.cmd_s2.ba == 2'(b);
        col_v[b] = r.cke_s2 && (cmd == CMD_READ || cmd == CMD_WRITE) &&
                   r.cmd_s2.a10 && r.cmd_s2.ba == 2'(b);
        pre_v[b] = r.cke_s2 && cmd == CMD_PRE && (r.cmd_s2.a10 || r.cmd_s2.ba == 2'(b));
      end
      lpddr_bank_ap u_ap (
        .clk(clk),
        .nrst(nrst),
        .act(act_v[b] && r.st inside {ST_IDLE, ST_ACTIVE}),
        .col_ap(col_v[b] && r.st == ST_ACTIVE),
        .is_write(cmd == CMD_WRITE),
        .pre((pre_v[b] && r.st inside {ST_IDLE, ST_ACTIVE}) || r.st == ST_DEEP),
        .open_o(b_open[b]),
        .ap_busy_o(b_ap[b])
      );
    end
  endgenerate

  always_comb begin
    nxt = r;
    nxt.cke_s1 = cke_pin;
    nxt.cke_s2 = r.cke_s1;
    nxt.run_s1 = clk_running;
    nxt.run_s2 = r.run_s1;
    nxt.cmd_s1 = cmd_pin;
    nxt.cmd_s2 = r.cmd_s1;
    nxt.ref_p = 1'b0;
    nxt.open_v = b_open | b_ap;
    nxt.ref_en = (r.st == ST_SELF_REF) ? pasr_mask(sr_cfg.pasr) : 4'hf;
    if (r.cnt != 13'h0000) nxt.cnt = r.cnt - 13'h0001;
    unique case (r.st)
      ST_IDLE, ST_ACTIVE: begin
        if (!r.run_s2) nxt.st = ST_CLK_STOP;
        else if (!r.cke_s2 && cmd == CMD_REF && r.st == ST_IDLE) begin
          nxt.st = ST_SELF_REF;
          nxt.bufs = 1'b0;
          nxt.cnt = sr_interval(sr_cfg.temp);
        end else if (!r.cke_s2 && cmd == CMD_BST && r.cmd_s2.ras_n && r.cmd_s2.cas_n
                     && !r.cmd_s2.we_n && !r.cmd_s2.cs_n) begin
          nxt.st = ST_DEEP;
          nxt.bufs = 1'b0;
          nxt.lost = 1'b1;
          nxt.init = 1'b1;
        end else if (!r.cke_s2) begin
          nxt.st = (b_open != '0) ? ST_PD_ACT : ST_PD_PRE;
          nxt.bufs = 1'b0;
        end else if (cmd == CMD_REF && r.st == ST_IDLE) begin
          // one refresh per command, row from own counter, address ignored
          nxt.st = ST_REFRESH;
          nxt.ref_p = 1'b1;
          nxt.row = r.row + `ROW_W'(1);
          nxt.cnt = 13'(`T_RFC_CYC);
        end else nxt.st = (b_open != '0) ? ST_ACTIVE : ST_IDLE;
        if (cmd == CMD_MRS && r.cke_s2) nxt.init = 1'b0;
      end
      ST_REFRESH: begin
        // bus assumed quiet here, commands are not watched
        if (r.cnt == 13'h0000) nxt.st = ST_IDLE;
      end
      ST_SELF_REF: begin
        // inputs other than cke ignored, internal timer paces refresh
        if (r.cnt == 13'h0000) begin
          nxt.ref_p = 1'b1;
          nxt.row = r.row + `ROW_W'(1);
          nxt.cnt = sr_interval(sr_cfg.temp);
        end
        if (r.cke_s2) begin
          nxt.st = ST_REFRESH;
          nxt.bufs = 1'b1;
          nxt.cnt = 13'(`T_XSR_CYC);
        end
      end
      ST_PD_PRE, ST_PD_ACT: begin
        if (r.cke_s2 && (cmd == CMD_NOP || cmd == CMD_DESEL)) begin
          nxt.st = (r.st == ST_PD_ACT) ? ST_ACTIVE : ST_IDLE;
          nxt.bufs = 1'b1;
        end
      end
      ST_DEEP: begin
        if (r.cke_s2) begin
          nxt.st = ST_IDLE;
          nxt.bufs = 1'b1;
        end
      end
      ST_CLK_STOP: begin
        if (r.run_s2) nxt.st = (b_open != '0) ? ST_ACTIVE : ST_IDLE;
      end
    endcase
    if (!nrst) begin
      nxt = '0;
      nxt.st = ST_IDLE;
      nxt.bufs = 1'b1;
      nxt.init = 1'b1;
      // syncs start at idle pin levels, no false stop or sleep after reset
      nxt.cke_s1 = 1'b1;
      nxt.cke_s2 = 1'b1;
      nxt.run_s1 = 1'b1;
      nxt.run_s2 = 1'b1;
      nxt.cmd_s1.cs_n = 1'b1;
      nxt.cmd_s2.cs_n = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    r <= nxt;
  end

  assign pwr_state = r.st;
  assign buffers_on = r.bufs;
  assign refresh_pulse = r.ref_p;
  assign refresh_row = r.row;
  assign refresh_bank_en = r.ref_en;
  assign bank_open = r.open_v;
  assign array_lost = r.lost;
  assign need_init = r.init;
endmodule // lpddr_refresh_power_state
`default_nettype wire

// *** lpddr_refresh_power_state_properties.sv ***
// assertion checker for the refresh and power-state block
`timescale 1ns/100ps
`default_nettype none
`include "lpddr_pwr_regs.svh"
module lpddr_refresh_power_state_properties import lpddr_pwr_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cke_pin,
  input wire cmd_bus_s cmd_pin,
  input wire logic clk_running,
  input wire sr_cfg_s sr_cfg,
  input wire logic [7:0] pwr_state,
  input wire logic buffers_on,
  input wire logic refresh_pulse,
  input wire logic [`ROW_W-1:0] refresh_row,
  input wire logic [`NUM_BANKS-1:0] refresh_bank_en,
  input wire logic [`NUM_BANKS-1:0] bank_open,
  input wire logic array_lost,
  input wire logic need_init
);
  logic cke_q;
  wire logic [3:0] code = {cmd_pin.cs_n, cmd_pin.ras_n, cmd_pin.cas_n, cmd_pin.we_n};
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // previous cke level, to spot the falling edge
  always_ff @(posedge clk) cke_q <= cke_pin;
  AST_PULSE_ONE: assert property (refresh_pulse |=> !refresh_pulse)
    else $error("refresh pulse too long");
  AST_ROW_STEP: assert property (refresh_pulse |-> refresh_row == $past(refresh_row) + 1'b1)
    else $error("refresh row not stepped");
  AST_REF_SPAN: assert property (refresh_pulse && $past(pwr_state) == 8'h01 |->
    ##1 (pwr_state == 8'h04)[*8] ##1 pwr_state == 8'h01) else $error("refresh span wrong");
  AST_SR_ENTER: assert property (pwr_state == 8'h01 && cke_q && !cke_pin && code == 4'h1
    |-> ##3 pwr_state == 8'h08) else $error("no self refresh entry");
  AST_PD_ENTER: assert property ((pwr_state == 8'h01 || pwr_state == 8'h02) && cke_q &&
    !cke_pin && code == 4'h7 |-> ##3 pwr_state == (bank_open == 0 ? 8'h10 : 8'h20))
    else $error("wrong power-down entry");
  AST_BUF_OFF: assert property (pwr_state inside {8'h08, 8'h10, 8'h20, 8'h40} |-> !buffers_on)
    else $error("buffers on while asleep");
  AST_DEEP_ENTER: assert property (pwr_state == 8'h01 && cke_q && !cke_pin && code == 4'h6
    |-> ##3 pwr_state == 8'h40 ##[0:1] array_lost) else $error("no deepest sleep entry");
  AST_DEEP_STAY: assert property (pwr_state == 8'h40 && !$past(cke_pin, 2) |=> pwr_state == 8'h40)
    else $error("left deepest sleep with cke low");
  AST_SR_BANKS: assert property (pwr_state == 8'h08 && refresh_pulse |-> refresh_bank_en ==
    (sr_cfg.pasr == 3'h1 ? 4'h3 : sr_cfg.pasr == 3'h2 ? 4'h1 : 4'hf)) else $error("bad bank mask");
  AST_SR_EXIT: assert property (pwr_state == 8'h08 ##1 pwr_state == 8'h04 |->
    ##12 pwr_state == 8'h04 ##1 pwr_state == 8'h01) else $error("self refresh exit span wrong");
  COV_SELF: cover property (pwr_state == 8'h08 && refresh_pulse);
  COV_DEEP: cover property (pwr_state == 8'h40);
  COV_STOP: cover property (pwr_state == 8'h80);
endmodule // lpddr_refresh_power_state_properties
bind lpddr_refresh_power_state lpddr_refresh_power_state_properties lpddr_refresh_power_state_properties_inst (
  .clk, .nrst, .cke_pin, .cmd_pin, .clk_running, .sr_cfg, .pwr_state, .buffers_on,
  .refresh_pulse, .refresh_row, .refresh_bank_en, .bank_open, .array_lost, .need_init);
`default_nettype wire

// *** lpddr_refresh_power_state_tb.sv ***
// self-checking bench for the refresh and power-state block
`timescale 1ns/100ps
`default_nettype none
`include "lpddr_pwr_regs.svh"
module lpddr_refresh_power_state_tb import lpddr_pwr_pkg::*;;
  localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, RD = 4'h5, PRE = 4'h2;
  localparam logic [3:0] REF = 4'h1, MRS = 4'h0, DEEP = 4'h6;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_running = 1'b1;
  sr_cfg_s sr_cfg = 5'h04;
  logic cke_pin, buffers_on, refresh_pulse, array_lost, need_init;
  cmd_bus_s cmd_pin;
  logic [7:0] pwr_state;
  logic [`ROW_W-1:0] refresh_row;
  logic [3:0] refresh_bank_en, bank_open;
  int n_fail = 0;
  int n_tests = 0;
  int n_pulse = 0;
  int n_base = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (refresh_pulse === 1'b1) n_pulse++;
  lpddr_refresh_power_state lpddr_refresh_power_state_inst (.clk, .nrst, .cke_pin, .cmd_pin,
    .clk_running, .sr_cfg, .pwr_state, .buffers_on, .refresh_pulse, .refresh_row,
    .refresh_bank_en, .bank_open, .array_lost, .need_init);
  lpddr_ctrl_model lpddr_ctrl_model_inst (.clk, .cke_pin, .cmd_pin);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // settle one step past the edge before anyone looks
  task automatic go(input logic [3:0] c, input logic k, input int n);
    lpddr_ctrl_model_inst.put(c, k, 1'b0, 2'h0, n);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk({pwr_state, buffers_on, array_lost, need_init}, 11'h00d);
    go(MRS, 1'b1, 1);
    go(NOP, 1'b1, 4);
    chk(need_init, 1'b0);
    // junk address on the first refresh must not matter
    lpddr_ctrl_model_inst.put(REF, 1'b1, 1'b1, 2'h3, 1);
    go(NOP, 1'b1, 3);
    chk(pwr_state, 8'h04);
    go(NOP, 1'b1, 9);
    chk(pwr_state, 8'h01);
    go(REF, 1'b1, 1);
    go(NOP, 1'b1, 12);
    chk(refresh_row, 14'h2);
    chk(16'(n_pulse), 16'h2);
    $display("refresh test done");
    lpddr_ctrl_model_inst.put(ACT, 1'b1, 1'b0, 2'h1, 1);
    go(NOP, 1'b1, 4);
    chk(pwr_state, 8'h02);
    lpddr_ctrl_model_inst.put(RD, 1'b1, 1'b1, 2'h1, 1);
    lpddr_ctrl_model_inst.put(ACT, 1'b1, 1'b0, 2'h2, 1);
    go(NOP, 1'b1, 4);
    chk(bank_open, 4'h6);
    go(NOP, 1'b1, 20);
    chk(bank_open, 4'h4);
    go(NOP, 1'b0, 4);
    chk(pwr_state, 8'h20);
    go(NOP, 1'b1, 4);
    chk(pwr_state, 8'h02);
    lpddr_ctrl_model_inst.put(PRE, 1'b1, 1'b1, 2'h0, 1);
    go(NOP, 1'b1, 4);
    chk({pwr_state, bank_open}, 12'h010);
    $display("bank test done");
    go(NOP, 1'b0, 4);
    chk({pwr_state, buffers_on}, 9'h020);
    go(NOP, 1'b1, 4);
    chk({pwr_state, buffers_on}, 9'h003);
    $display("power-down test done");
    go(REF, 1'b0, 1);
    go(NOP, 1'b0, 3);
    chk({pwr_state, buffers_on}, 9'h010);
    n_base = n_pulse;
    go(NOP, 1'b0, 900);
    chk(16'(n_pulse > n_base), 16'h1);
    chk(refresh_bank_en, 4'h3);
    go(NOP, 1'b1, 4);
    chk(pwr_state, 8'h04);
    go(NOP, 1'b1, 13);
    chk(pwr_state, 8'h01);
    go(REF, 1'b1, 1);
    go(NOP, 1'b1, 12);
    chk(refresh_row, 14'h4);
    chk(refresh_bank_en, 4'hf);
    $display("self refresh test done");
    @(posedge clk) clk_running <= 1'b0;
    go(NOP, 1'b1, 4);
    chk(pwr_state, 8'h80);
    @(posedge clk) clk_running <= 1'b1;
    go(NOP, 1'b1, 4);
    chk(pwr_state, 8'h01);
    $display("clock stop test done");
    chk(bank_open, 4'h0);
    go(DEEP, 1'b0, 1);
    go(NOP, 1'b0, 4);
    chk({pwr_state, array_lost, need_init}, 10'h103);
    go(NOP, 1'b1, 4);
    chk({pwr_state, need_init}, 9'h003);
    $display("deepest sleep test done");
    end_of_test();
  end
  // run needs about 1050 cycles; ten thousand is ample
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end
endmodule // lpddr_refresh_power_state_tb
`default_nettype wire
